// file: core/flash_seq_pkg.sv
// constants, codes and state types for the flash sequencer status logic
package flash_seq_pkg;
  // clock and documented times
  localparam int CLK_NS         = 8;
  localparam int PROT_PROG_NS   = 2000;
  localparam int PROT_ERASE_NS  = 100000;
  localparam int ERASE_WAIT_NS  = 50000;
  localparam int PROT_PROG_CYC  = (PROT_PROG_NS / CLK_NS) > 0 ?
                                  (PROT_PROG_NS / CLK_NS) : 1;
  localparam int PROT_ERASE_CYC = (PROT_ERASE_NS / CLK_NS) > 0 ?
                                  (PROT_ERASE_NS / CLK_NS) : 1;
  localparam int ERASE_WAIT_CYC = (ERASE_WAIT_NS / CLK_NS) > 0 ?
                                  (ERASE_WAIT_NS / CLK_NS) : 1;
  localparam int PROG_PULSE_CYC = 8;
  localparam int PULSE_LIMIT    = 16;
  localparam int TIMER_W        = 16;
  localparam int PULSE_W        = 8;

  // bus and array geometry
  localparam int ADDR_W    = 16;
  localparam int DATA_W    = 16;
  localparam int WADDR_W   = ADDR_W - 1;
  localparam int SECT_BITS = 3;
  localparam int NSECT     = 1 << SECT_BITS;
  localparam logic [1:0]        WORD_ENABLES = 2'h3;
  localparam logic [DATA_W-1:0] ERASED_WORD  = 16'hffff;

  // command addresses and codes
  localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 16'haaaa;
  localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 16'h5554;
  localparam logic [7:0] CODE_UNLOCK1 = 8'haa;
  localparam logic [7:0] CODE_UNLOCK2 = 8'h55;
  localparam logic [7:0] CODE_RESET   = 8'hf0;
  localparam logic [7:0] CODE_PROG    = 8'ha0;
  localparam logic [7:0] CODE_ERASE   = 8'h80;
  localparam logic [7:0] CODE_CHIP    = 8'h10;
  localparam logic [7:0] CODE_SECTOR  = 8'h30;
  localparam logic [7:0] CODE_SUSPEND = 8'hb0;

  // status bit positions
  localparam int POLL_BIT    = 7;
  localparam int TOGGLE_BIT  = 6;
  localparam int TIMEOUT_BIT = 5;
  localparam int WINDOW_BIT  = 3;

  typedef enum logic [2:0] {
    CMD_RESET    = 3'h0,
    CMD_PROG     = 3'h1,
    CMD_CHIP     = 3'h2,
    CMD_SECTOR   = 3'h3,
    CMD_SINGLE30 = 3'h4,
    CMD_SUSPEND  = 3'h5
  } cmd_code_t;

  typedef enum logic [2:0] {
    DEC_IDLE = 3'h0,
    DEC_U1   = 3'h1,
    DEC_U2   = 3'h2,
    DEC_PROG = 3'h3,
    DEC_E1   = 3'h4,
    DEC_E2   = 3'h5,
    DEC_E3   = 3'h6
  } dec_state_t;

  typedef enum logic [2:0] {
    ST_READ       = 3'h0,
    ST_PROG       = 3'h1,
    ST_PROG_PROT  = 3'h2,
    ST_LOCKED     = 3'h3,
    ST_ERASE_WAIT = 3'h4,
    ST_ERASE      = 3'h5,
    ST_SUSPEND    = 3'h6,
    ST_ERASE_PROT = 3'h7
  } seq_state_t;
endpackage

// file: core/cmd_if.sv
// decoded command carrier between the sequence decoder and the sequencer
`timescale 1ns/1ns
`default_nettype none
interface cmd_if
  import flash_seq_pkg::*;
();
  logic                valid;
  cmd_code_t           code;
  logic [ADDR_W-1:0]   addr;
  logic [DATA_W-1:0]   data;
  modport src (output valid, output code, output addr, output data);
  modport dst (input valid, input code, input addr, input data);
endinterface
`default_nettype wire

// file: core/cycle_timer.sv
// down counter that pulses once when a loaded cycle count runs out
`timescale 1ns/1ns
`default_nettype none
module cycle_timer
  import flash_seq_pkg::*;
#(
  parameter int W = TIMER_W
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  // control
  input  wire logic         start_in,
  input  wire logic         stop_in,
  input  wire logic [W-1:0] load_in,
  // status
  output logic              expire_out
);
  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;
  logic         run_r;
  logic         run_nxt;
  logic         expire_r;
  logic         expire_nxt;

  always_comb begin
    count_nxt  = count_r;
    run_nxt    = run_r;
    expire_nxt = 1'b0;
    if (start_in) begin
      count_nxt = load_in;
      run_nxt   = 1'b1;
    end else if (stop_in) begin
      run_nxt = 1'b0;
    end else if (run_r) begin
      if (count_r <= W'(1)) begin
        run_nxt    = 1'b0;
        expire_nxt = 1'b1;
      end else begin
        count_nxt = count_r - W'(1);
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_r  <= '0;
      run_r    <= 1'b0;
      expire_r <= 1'b0;
    end else begin
      count_r  <= count_nxt;
      run_r    <= run_nxt;
      expire_r <= expire_nxt;
    end
  end

  assign expire_out = expire_r;
endmodule
`default_nettype wire

// file: core/cmd_decoder.sv
// turns bus write cycles into decoded flash commands
`timescale 1ns/1ns
`default_nettype none
module cmd_decoder
  import flash_seq_pkg::*;
(
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  // accepted word writes
  input  wire logic              wr_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] data_in,
  // decoded command
  cmd_if.src                     cmd
);
  dec_state_t        st_r;
  dec_state_t        st_nxt;
  logic              valid_r;
  logic              valid_nxt;
  cmd_code_t         code_r;
  cmd_code_t         code_nxt;
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;
  logic [DATA_W-1:0] data_r;
  logic [DATA_W-1:0] data_nxt;
  logic [7:0]        lo;

  // only the low byte carries the command code
  assign lo = data_in[7:0];

  always_comb begin
    st_nxt    = st_r;
    valid_nxt = 1'b0;
    code_nxt  = code_r;
    addr_nxt  = addr_r;
    data_nxt  = data_r;
    if (wr_in) begin
      st_nxt   = DEC_IDLE;
      addr_nxt = addr_in;
      data_nxt = data_in;
      case (st_r)
        DEC_IDLE: begin
          if (lo == CODE_UNLOCK1 && addr_in == UNLOCK1_ADDR) begin
            st_nxt = DEC_U1;
          end else if (lo == CODE_RESET) begin
            valid_nxt = 1'b1;
            code_nxt  = CMD_RESET;
          end else if (lo == CODE_SUSPEND) begin
            valid_nxt = 1'b1;
            code_nxt  = CMD_SUSPEND;
          end else if (lo == CODE_SECTOR) begin
            valid_nxt = 1'b1;
            code_nxt  = CMD_SINGLE30;
          end
        end
        DEC_U1: begin
          if (lo == CODE_UNLOCK2 && addr_in == UNLOCK2_ADDR) begin
            st_nxt = DEC_U2;
          end
        end
        DEC_U2: begin
          if (addr_in == UNLOCK1_ADDR) begin
            if (lo == CODE_RESET) begin
              valid_nxt = 1'b1;
              code_nxt  = CMD_RESET;
            end else if (lo == CODE_PROG) begin
              st_nxt = DEC_PROG;
            end else if (lo == CODE_ERASE) begin
              st_nxt = DEC_E1;
            end
          end
        end
        DEC_PROG: begin
          valid_nxt = 1'b1;
          code_nxt  = CMD_PROG;
        end
        DEC_E1: begin
          if (lo == CODE_UNLOCK1 && addr_in == UNLOCK1_ADDR) begin
            st_nxt = DEC_E2;
          end
        end
        DEC_E2: begin
          if (lo == CODE_UNLOCK2 && addr_in == UNLOCK2_ADDR) begin
            st_nxt = DEC_E3;
          end
        end
        DEC_E3: begin
          if (lo == CODE_CHIP && addr_in == UNLOCK1_ADDR) begin
            valid_nxt = 1'b1;
            code_nxt  = CMD_CHIP;
          end else if (lo == CODE_SECTOR) begin
            valid_nxt = 1'b1;
            code_nxt  = CMD_SECTOR;
          end
        end
        default: st_nxt = DEC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r    <= DEC_IDLE;
      valid_r <= 1'b0;
      code_r  <= CMD_RESET;
      addr_r  <= '0;
      data_r  <= '0;
    end else begin
      st_r    <= st_nxt;
      valid_r <= valid_nxt;
      code_r  <= code_nxt;
      addr_r  <= addr_nxt;
      data_r  <= data_nxt;
    end
  end

  assign cmd.valid = valid_r;
  assign cmd.code  = code_r;
  assign cmd.addr  = addr_r;
  assign cmd.data  = data_r;
endmodule
`default_nettype wire

// file: core/flash_seq_top.sv
// flash array with automatic program/erase sequencer and status flags
// Operation
// - toggle flag inverts on each read while busy, except when erase is suspended
// - after completion, reads return true bit 6
// - suspended sector reads toggle position as 1
// - protected program: toggle about 2 us, no change
// - all-protected erase: toggle 100 us, then idle
// - timeout flag 0 within pulse limit, else 1
// - programming 0 to 1 locks with timeout set
// - locked state left only by read/reset
// - erase window flag 0 during wait, then 1; all-protected erase keeps it 0
// - while erasing, only suspend is accepted
// - during wait, more sector codes add sectors
// - suspended sector reads window position as 1
// - completed algorithm returns to read/reset state
// - one-write and three-write reset act alike
// - power-on enters read/reset state
// - read/reset aborts stuck or wrongly ended algorithm
// - flags on bits 7, 6, 5 and 3
// - polling bit returns inverse of written bit 7
`timescale 1ns/1ns
`default_nettype none
module flash_seq_top
  import flash_seq_pkg::*;
#(
  parameter int ERASE_WAIT_CYC_P = ERASE_WAIT_CYC,
  parameter int PROT_ERASE_CYC_P = PROT_ERASE_CYC,
  parameter int PROG_PULSE_CYC_P = PROG_PULSE_CYC,
  parameter int PULSE_LIMIT_P    = PULSE_LIMIT
) (
  // clock and reset
  input  wire logic              sys_clk_in,
  input  wire logic              rst_b_in,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [DATA_W-1:0] avs_writedata_in,
  input  wire logic [1:0]        avs_byteenable_in,
  output logic [DATA_W-1:0]      avs_readdata_out,
  output logic                   avs_waitrequest_out,
  // sector protection and status
  input  wire logic [NSECT-1:0]  protect_in,
  output logic                   busy_out,
  output logic                   timeout_out
);
  logic rst_meta_r;
  logic rst_sync_r;

  // reset released through two flops
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  cmd_if cmd ();

  logic wr_word;
  assign wr_word = avs_write_in && (avs_byteenable_in == WORD_ENABLES);

  cmd_decoder u_dec (
    .clk_in   (sys_clk_in),
    .rst_n_in (rst_sync_r),
    .wr_in    (wr_word),
    .addr_in  (avs_address_in),
    .data_in  (avs_writedata_in),
    .cmd      (cmd.src)
  );

  logic               tmr_start;
  logic               tmr_stop;
  logic [TIMER_W-1:0] tmr_load;
  logic               tmr_expire;

  cycle_timer #(.W(TIMER_W)) u_tmr (
    .clk_in     (sys_clk_in),
    .rst_n_in   (rst_sync_r),
    .start_in   (tmr_start),
    .stop_in    (tmr_stop),
    .load_in    (tmr_load),
    .expire_out (tmr_expire)
  );

  // array storage
  logic [DATA_W-1:0]  mem [0:(1<<WADDR_W)-1];
  logic               mem_we;
  logic [WADDR_W-1:0] mem_wa;
  logic [DATA_W-1:0]  mem_wd;

  always_ff @(posedge sys_clk_in) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  seq_state_t         st_r;
  seq_state_t         st_nxt;
  logic               toggle_r;
  logic               toggle_nxt;
  logic               timeout_r;
  logic               timeout_nxt;
  logic [DATA_W-1:0]  last_r;
  logic [DATA_W-1:0]  last_nxt;
  logic [WADDR_W-1:0] pa_r;
  logic [WADDR_W-1:0] pa_nxt;
  logic [PULSE_W-1:0] pulse_r;
  logic [PULSE_W-1:0] pulse_nxt;
  logic [NSECT-1:0]   mark_r;
  logic [NSECT-1:0]   mark_nxt;
  logic [WADDR_W-1:0] ep_r;
  logic [WADDR_W-1:0] ep_nxt;
  logic               rd_valid_r;
  logic               rd_valid_nxt;
  logic [DATA_W-1:0]  rdata_r;
  logic [DATA_W-1:0]  rdata_nxt;

  logic [WADDR_W-1:0]   cmd_wa;
  logic [SECT_BITS-1:0] cmd_sec;
  logic [NSECT-1:0]     cmd_bit;
  logic [WADDR_W-1:0]   rd_wa;
  logic [SECT_BITS-1:0] rd_sec;
  logic [DATA_W-1:0]    stored;
  logic [DATA_W-1:0]    status;
  logic [DATA_W-1:0]    prog_old;
  logic                 rd_go;
  logic                 toggling;

  assign cmd_wa   = cmd.addr[ADDR_W-1:1];
  assign cmd_sec  = cmd_wa[WADDR_W-1 -: SECT_BITS];
  assign rd_wa    = avs_address_in[ADDR_W-1:1];
  assign rd_sec   = rd_wa[WADDR_W-1 -: SECT_BITS];
  assign stored   = mem[rd_wa];
  assign prog_old = mem[pa_r];
  assign rd_go    = avs_read_in && !rd_valid_r;

  // sequencer
  always_comb begin
    st_nxt      = st_r;
    timeout_nxt = timeout_r;
    last_nxt    = last_r;
    pa_nxt      = pa_r;
    pulse_nxt   = pulse_r;
    mark_nxt    = mark_r;
    ep_nxt      = ep_r;
    tmr_start   = 1'b0;
    tmr_stop    = 1'b0;
    tmr_load    = '0;
    mem_we      = 1'b0;
    mem_wa      = pa_r;
    mem_wd      = last_r;
    cmd_bit     = '0;
    cmd_bit[cmd_sec] = 1'b1;
    case (st_r)
      ST_READ: begin
        if (cmd.valid && cmd.code == CMD_PROG) begin
          pa_nxt      = cmd_wa;
          last_nxt    = cmd.data;
          pulse_nxt   = '0;
          timeout_nxt = 1'b0;
          tmr_start   = 1'b1;
          if (protect_in[cmd_sec]) begin
            st_nxt   = ST_PROG_PROT;
            tmr_load = TIMER_W'(PROT_PROG_CYC);
          end else begin
            st_nxt   = ST_PROG;
            tmr_load = TIMER_W'(PROG_PULSE_CYC_P);
          end
        end else if (cmd.valid && cmd.code == CMD_CHIP) begin
          mark_nxt  = ~protect_in;
          ep_nxt    = '0;
          tmr_start = (protect_in == '1);
          tmr_load  = TIMER_W'(PROT_ERASE_CYC_P);
          st_nxt    = (protect_in == '1) ? ST_ERASE_PROT : ST_ERASE;
        end else if (cmd.valid && cmd.code == CMD_SECTOR) begin
          mark_nxt  = protect_in[cmd_sec] ? '0 : cmd_bit;
          st_nxt    = ST_ERASE_WAIT;
          tmr_start = 1'b1;
          tmr_load  = TIMER_W'(ERASE_WAIT_CYC_P);
        end
      end
      ST_PROG: begin
        if (tmr_expire) begin
          if ((last_r & ~prog_old) == '0) begin
            mem_we = 1'b1;
            st_nxt = ST_READ;
          end else if (pulse_r + PULSE_W'(1) >= PULSE_W'(PULSE_LIMIT_P)) begin
            timeout_nxt = 1'b1;
            st_nxt      = ST_LOCKED;
          end else begin
            pulse_nxt = pulse_r + PULSE_W'(1);
            tmr_start = 1'b1;
            tmr_load  = TIMER_W'(PROG_PULSE_CYC_P);
          end
        end
      end
      ST_PROG_PROT: begin
        if (tmr_expire) begin
          st_nxt = ST_READ;
        end
      end
      ST_LOCKED: begin
        if (cmd.valid && cmd.code == CMD_RESET) begin
          timeout_nxt = 1'b0;
          st_nxt      = ST_READ;
        end
      end
      ST_ERASE_WAIT: begin
        if (cmd.valid && (cmd.code == CMD_SECTOR ||
                          cmd.code == CMD_SINGLE30)) begin
          if (!protect_in[cmd_sec]) begin
            mark_nxt = mark_r | cmd_bit;
          end
          tmr_start = 1'b1;
          tmr_load  = TIMER_W'(ERASE_WAIT_CYC_P);
        end else if (cmd.valid && cmd.code == CMD_SUSPEND) begin
          tmr_stop = 1'b1;
          ep_nxt   = '0;
          st_nxt   = ST_SUSPEND;
        end else if (cmd.valid && cmd.code == CMD_RESET) begin
          tmr_stop = 1'b1;
          mark_nxt = '0;
          st_nxt   = ST_READ;
        end else if (tmr_expire) begin
          ep_nxt = '0;
          if (mark_r == '0) begin
            tmr_start = 1'b1;
            tmr_load  = TIMER_W'(PROT_ERASE_CYC_P);
            st_nxt    = ST_ERASE_PROT;
          end else begin
            st_nxt = ST_ERASE;
          end
        end
      end
      ST_ERASE: begin
        if (cmd.valid && cmd.code == CMD_SUSPEND) begin
          st_nxt = ST_SUSPEND;
        end else begin
          mem_we = mark_r[ep_r[WADDR_W-1 -: SECT_BITS]];
          mem_wa = ep_r;
          mem_wd = ERASED_WORD;
          ep_nxt = ep_r + WADDR_W'(1);
          if (ep_r == '1) begin
            mark_nxt = '0;
            st_nxt   = ST_READ;
          end
        end
      end
      ST_SUSPEND: begin
        if (cmd.valid && cmd.code == CMD_SINGLE30) begin
          st_nxt = ST_ERASE;
        end else if (cmd.valid && cmd.code == CMD_RESET) begin
          mark_nxt = '0;
          st_nxt   = ST_READ;
        end
      end
      ST_ERASE_PROT: begin
        if (tmr_expire) begin
          st_nxt = ST_READ;
        end
      end
      default: st_nxt = ST_READ;
    endcase
  end

  // read path with sequence flags
  always_comb begin
    status   = stored;
    toggling = 1'b1;
    case (st_r)
      ST_PROG, ST_PROG_PROT, ST_LOCKED: begin
        status[POLL_BIT]    = ~last_r[POLL_BIT];
        status[TOGGLE_BIT]  = toggle_r;
        status[TIMEOUT_BIT] = timeout_r;
        status[WINDOW_BIT]  = 1'b0;
      end
      ST_ERASE_WAIT, ST_ERASE_PROT: begin
        status[POLL_BIT]    = 1'b0;
        status[TOGGLE_BIT]  = toggle_r;
        status[TIMEOUT_BIT] = 1'b0;
        status[WINDOW_BIT]  = 1'b0;
      end
      ST_ERASE: begin
        status[POLL_BIT]    = 1'b0;
        status[TOGGLE_BIT]  = toggle_r;
        status[TIMEOUT_BIT] = timeout_r;
        status[WINDOW_BIT]  = 1'b1;
      end
      ST_SUSPEND: begin
        toggling = 1'b0;
        if (mark_r[rd_sec]) begin
          status[POLL_BIT]    = 1'b1;
          status[TOGGLE_BIT]  = 1'b1;
          status[TIMEOUT_BIT] = 1'b0;
          status[WINDOW_BIT]  = 1'b1;
        end
      end
      default: toggling = 1'b0;
    endcase
    rd_valid_nxt = rd_go;
    rdata_nxt    = rd_go ? status : rdata_r;
    toggle_nxt   = (rd_go && toggling) ? ~toggle_r : toggle_r;
  end

  always_ff @(posedge sys_clk_in or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      st_r       <= ST_READ;
      toggle_r   <= 1'b0;
      timeout_r  <= 1'b0;
      last_r     <= '0;
      pa_r       <= '0;
      pulse_r    <= '0;
      mark_r     <= '0;
      ep_r       <= '0;
      rd_valid_r <= 1'b0;
      rdata_r    <= '0;
    end else begin
      st_r       <= st_nxt;
      toggle_r   <= toggle_nxt;
      timeout_r  <= timeout_nxt;
      last_r     <= last_nxt;
      pa_r       <= pa_nxt;
      pulse_r    <= pulse_nxt;
      mark_r     <= mark_nxt;
      ep_r       <= ep_nxt;
      rd_valid_r <= rd_valid_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  // writes never stall; reads stall one cycle
  assign avs_waitrequest_out = avs_read_in && !rd_valid_r;
  assign avs_readdata_out    = rdata_r;
  assign busy_out            = (st_r != ST_READ);
  assign timeout_out         = timeout_r;
endmodule
`default_nettype wire

// file: testbench/flash_chk_asserts.sv
// port-level checks on the flash sequencer status logic
`timescale 1ns/1ns
`default_nettype none
module flash_chk
  import flash_seq_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk_in,
  input  wire logic              rst_b_in,
  // bus and status
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [DATA_W-1:0] avs_writedata_in,
  input  wire logic [DATA_W-1:0] avs_readdata_out,
  input  wire logic              avs_waitrequest_out,
  input  wire logic              busy_out,
  input  wire logic              timeout_out
);
  logic rd_done;
  logic prev6_r;
  logic lock_rd_r;
  logic wr7_r;
  assign rd_done = avs_read_in && !avs_waitrequest_out;
  // last completed read and last written bit 7
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prev6_r   <= 1'b0;
      lock_rd_r <= 1'b0;
      wr7_r     <= 1'b0;
    end else begin
      if (rd_done) begin
        prev6_r   <= avs_readdata_out[6];
        lock_rd_r <= timeout_out;
      end else if (!timeout_out) begin
        lock_rd_r <= 1'b0;
      end
      if (avs_write_in) begin
        wr7_r <= avs_writedata_in[7];
      end
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  reset_idle_a: assert property (
    $rose(rst_b_in) |-> !busy_out && !timeout_out)
    else $error("busy or timeout after reset");
  lock_busy_a: assert property (
    timeout_out |-> busy_out)
    else $error("timeout outside busy");
  lock_hold_a: assert property (
    $fell(timeout_out) |-> $past(avs_write_in, 2) ||
      $past(avs_write_in, 3) || $past(avs_write_in, 4))
    else $error("timeout cleared without command");
  lock_flags_a: assert property (
    rd_done && timeout_out && $past(timeout_out) |-> avs_readdata_out[5] &&
      !avs_readdata_out[3] && avs_readdata_out[7] != wr7_r)
    else $error("locked status bits wrong");
  lock_toggle_a: assert property (
    rd_done && timeout_out && lock_rd_r |->
      avs_readdata_out[6] != prev6_r)
    else $error("toggle bit did not flip");
  data_stands_a: assert property (
    !(avs_read_in && avs_waitrequest_out) |=> $stable(avs_readdata_out))
    else $error("read data changed without read");
  tmo_cause_a: assert property (
    $rose(timeout_out) |-> $past(busy_out))
    else $error("timeout rose while idle");
  idle_clear_a: assert property (
    $fell(busy_out) |-> !timeout_out)
    else $error("idle with timeout set");
endmodule
bind flash_seq_top flash_chk chk (
  .sys_clk_in, .rst_b_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
  .avs_readdata_out, .avs_waitrequest_out, .busy_out, .timeout_out);
`default_nettype wire

// file: testbench/avm_master.sv
// avalon-mm master model standing in for the cpu
`timescale 1ns/1ns
`default_nettype none
module avm_master
  import flash_seq_pkg::*;
(
  // clock
  input  wire logic              clk_in,
  // request
  output logic [ADDR_W-1:0]      address_out,
  output logic                   read_out,
  output logic                   write_out,
  output logic [DATA_W-1:0]      writedata_out,
  output logic [1:0]             byteenable_out,
  // answer
  input  wire logic [DATA_W-1:0] readdata_in,
  input  wire logic              waitrequest_in
);
  initial begin
    address_out    = '0;
    read_out       = 1'b0;
    write_out      = 1'b0;
    writedata_out  = '0;
    byteenable_out = 2'h0;
  end
  // request held until the rising edge that sees waitrequest low
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d,
                      output logic [DATA_W-1:0] q);
    address_out    <= a;
    read_out       <= !w;
    write_out      <= w;
    writedata_out  <= d;
    byteenable_out <= WORD_ENABLES;
    do begin
      @(posedge clk_in);
    end while (waitrequest_in);
    q = readdata_in;
  endtask
  // released lines show inverted values, never the stale ones
  task automatic idle;
    read_out       <= 1'b0;
    write_out      <= 1'b0;
    address_out    <= ~address_out;
    writedata_out  <= ~writedata_out;
    byteenable_out <= 2'h0;
    @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// self-checking bench for the flash sequencer status logic
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import flash_seq_pkg::*;
;
  logic              sys_clk;
  logic              rst_b;
  logic [ADDR_W-1:0] addr;
  logic              rd;
  logic              wr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic [1:0]        be;
  logic              waitreq;
  logic              busy;
  logic              tmo;
  logic [NSECT-1:0]  prot;
  logic [DATA_W-1:0] q;
  logic [DATA_W-1:0] q2;
  logic [DATA_W-1:0] pa;
  logic [DATA_W-1:0] pd;
  logic [31:0]       seed;
  int                err_count;
  int                checked;
  int                cyc;
  int                n;

  initial sys_clk = 1'b0;
  always #4 sys_clk = ~sys_clk;
  initial begin
    rst_b = 1'b0;
    prot = '0;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
  end

  flash_seq_top #(.ERASE_WAIT_CYC_P(20), .PROT_ERASE_CYC_P(30),
    .PROG_PULSE_CYC_P(4), .PULSE_LIMIT_P(3)) DUT (
    .sys_clk_in(sys_clk), .rst_b_in(rst_b), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(be), .avs_readdata_out(rdata),
    .avs_waitrequest_out(waitreq), .protect_in(prot), .busy_out(busy),
    .timeout_out(tmo));
  avm_master m (.clk_in(sys_clk), .address_out(addr), .read_out(rd),
    .write_out(wr), .writedata_out(wdata), .byteenable_out(be),
    .readdata_in(rdata), .waitrequest_in(waitreq));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // polling, timeout and window bits expected while programming
  function automatic logic [2:0] prog_flags(input logic [DATA_W-1:0] d);
    return {~d[7], 2'b00};
  endfunction
  task automatic check(input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 80000) begin
      err_count++;
      end_sim();
    end
  end

  task automatic wrw(input logic [ADDR_W-1:0] a, input logic [7:0] c);
    m.xfer(1'b1, a, {8'h00, c}, q2);
  endtask
  // command writes go out back to back
  task automatic cmd(input logic [7:0] c);
    wrw(UNLOCK1_ADDR, CODE_UNLOCK1);
    wrw(UNLOCK2_ADDR, CODE_UNLOCK2);
    wrw(UNLOCK1_ADDR, c);
  endtask
  task automatic rdw(input logic [ADDR_W-1:0] a);
    m.xfer(1'b0, a, 16'h0000, q);
    m.idle();
  endtask
  task automatic prog(input logic [ADDR_W-1:0] a, [DATA_W-1:0] d);
    cmd(CODE_PROG);
    m.xfer(1'b1, a, d, q2);
    m.idle();
  endtask
  task automatic erase(input logic [ADDR_W-1:0] a, input logic [7:0] c);
    cmd(CODE_ERASE);
    wrw(UNLOCK1_ADDR, CODE_UNLOCK1);
    wrw(UNLOCK2_ADDR, CODE_UNLOCK2);
    wrw((c == CODE_SECTOR) ? a : UNLOCK1_ADDR, c);
    m.idle();
  endtask
  task automatic wait_idle(input int lim);
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (busy === 1'b1 && n < lim);
    @(posedge sys_clk);
  endtask

  initial begin
    seed = 32'hb522;
    wait (rst_b === 1'b1);
    repeat (3) @(posedge sys_clk);
    check(busy, 1'b0);
    erase(16'h0000, CODE_CHIP);
    rdw(16'h0010);
    q2 = q;
    rdw(16'h0010);
    check({q[7], q[5], q[3], q[6] ^ q2[6]}, 4'h3);
    wait_idle(40000);
    rdw(16'h1234);
    check({busy, q}, 17'h0ffff);
    $display("chip erase done");
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      pa = {3'h3, seed[12:1], 1'b0};
      pd = seed[31:16] & 16'hfffe;
      prog(pa, pd);
      rdw(pa);
      check({q[7], q[5], q[3]}, prog_flags(pd));
      wait_idle(100);
      rdw(pa);
      check(q, pd);
    end
    $display("program done");
    for (int f = 0; f < 2; f++) begin
      prog(pa, ~pd);
      n = 0;
      while (tmo !== 1'b1 && n < 200) begin
        @(negedge sys_clk);
        n++;
      end
      @(posedge sys_clk);
      rdw(pa);
      q2 = q;
      rdw(pa);
      check({tmo, q[5], q[3], q[6] ^ q2[6]}, 4'hd);
      if (f == 0) wrw(16'h0100, CODE_RESET);
      else cmd(CODE_RESET);
      m.idle();
      rdw(pa);
      check({busy, tmo, q}, {2'b00, pd});
    end
    $display("lock and reset done");
    prot <= 8'h08;
    prog(pa, pd & 16'h00ff);
    rdw(pa);
    wait_idle(400);
    check(n >= 230 && n <= 255, 1'b1);
    rdw(pa);
    check(q, pd);
    $display("protected program done");
    prot <= 8'h00;
    prog(16'h4002, pd);
    wait_idle(100);
    prog(16'h6000, pd);
    wait_idle(100);
    erase(16'h2000, CODE_SECTOR);
    rdw(16'h2000);
    check({q[7], q[5], q[3]}, 3'b000);
    wrw(16'h4000, CODE_SECTOR);
    m.idle();
    n = 0;
    do begin
      rdw(16'h2000);
      n++;
    end while (q[3] !== 1'b1 && n < 50);
    check(q[3], 1'b1);
    wrw(16'h6000, CODE_SECTOR);
    wrw(16'h0000, CODE_SUSPEND);
    m.idle();
    rdw(16'h2000);
    check({q[7], q[6], q[5], q[3]}, 4'hd);
    rdw(16'h4002);
    check({q[7], q[6], q[5], q[3]}, 4'hd);
    rdw(pa);
    check(q, pd);
    wrw(16'h0000, CODE_SECTOR);
    m.idle();
    wait_idle(40000);
    rdw(16'h4002);
    check(q, ERASED_WORD);
    rdw(16'h6000);
    check(q, pd);
    $display("sector erase done");
    prot <= 8'hff;
    erase(pa, CODE_SECTOR);
    rdw(pa);
    wait_idle(200);
    check(n >= 35 && n <= 55, 1'b1);
    rdw(pa);
    check({busy, q}, {1'b0, pd});
    $display("protected erase done");
    end_sim();
  end
endmodule
`default_nettype wire
